// file: rtl/dsc_dac_dev.sv
// Purpose: converter control end: shift in words, decode, hold registers
// Assumes: link clock only toggles inside frames
// Notes: channel index 0 is A, 1 is B
module dsc_dac_dev import dsc_pkg::*; (
    // system
    input wire logic i_clk,
    input wire logic i_resetn,
    // serial link
    dsc_link_if.dev link,
    // converter codes
    output logic [7:0] o_dac_a,
    output logic [7:0] o_dac_b,
    output logic o_transparent,
    // reference and power
    output logic o_ref_internal,
    output logic o_amp_on_a,
    output logic o_amp_on_b,
    output logic o_bias_on,
    output logic o_valid_a,
    output logic o_valid_b
);

////////////////////////////////////////////////////////////////////////////////
// link clock domain

logic frame_clr;
logic [4:0] bit_cnt_ff;
logic [15:0] shift_ff;
logic [15:0] word_ff;
logic good_ff;
logic frame_tgl_ff;

// idle sync holds the counter clear, so no edge is needed to restart
assign frame_clr = link.sync_n | ~i_resetn;

always_ff @(posedge link.sclk or posedge frame_clr) begin
    if (frame_clr) begin
        bit_cnt_ff <= 5'h00;
    end else if (bit_cnt_ff != CNT_OVER) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
end

always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
        shift_ff <= 16'h0000;
    end else if (!link.sync_n) begin
        shift_ff <= {shift_ff[14:0], link.din};
    end
end

// word snapshot stays put after the frame, read once sync rise is seen
always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
        word_ff <= 16'h0000;
        good_ff <= 1'b0;
    end else if (!link.sync_n) begin
        good_ff <= (bit_cnt_ff == CNT_FULL - 5'h01);
        if (bit_cnt_ff == CNT_FULL - 5'h01) begin
            word_ff <= {shift_ff[14:0], link.din};
        end
    end
end

// marks a frame that had any clock edge at all
always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
        frame_tgl_ff <= 1'b0;
    end else if (!link.sync_n && bit_cnt_ff == 5'h00) begin
        frame_tgl_ff <= ~frame_tgl_ff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// crossing into system clock

logic sync_meta_ff;
logic sync_ff;
logic sync_d_ff;
logic good_meta_ff;
logic good_s_ff;
logic tgl_meta_ff;
logic tgl_s_ff;
logic tgl_seen_ff;
logic exec;

always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        sync_meta_ff <= 1'b1;
        sync_ff <= 1'b1;
        sync_d_ff <= 1'b1;
        good_meta_ff <= 1'b0;
        good_s_ff <= 1'b0;
        tgl_meta_ff <= 1'b0;
        tgl_s_ff <= 1'b0;
    end else begin
        sync_meta_ff <= link.sync_n;
        sync_ff <= sync_meta_ff;
        sync_d_ff <= sync_ff;
        good_meta_ff <= good_ff;
        good_s_ff <= good_meta_ff;
        tgl_meta_ff <= frame_tgl_ff;
        tgl_s_ff <= tgl_meta_ff;
    end
end

// a frame with no clock edges leaves the toggle alone and is skipped
assign exec = sync_ff & ~sync_d_ff & good_s_ff & (tgl_s_ff != tgl_seen_ff);

always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        tgl_seen_ff <= 1'b0;
    end else if (sync_ff & ~sync_d_ff) begin
        tgl_seen_ff <= tgl_s_ff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// word fields

logic [7:0] data;
logic [1:0] lfunc;
logic sel;
logic upd;
logic [1:0] nxt_sleep;

assign data = word_ff[7:0];
assign lfunc = {word_ff[BIT_LF_HI], word_ff[BIT_LF_LO]};
assign sel = word_ff[BIT_SEL];
assign upd = word_ff[BIT_UPD];
assign nxt_sleep = {word_ff[BIT_SLP_B], word_ff[BIT_SLP_A]};

////////////////////////////////////////////////////////////////////////////////
// data registers

logic [7:0] in_ff [2];
logic [7:0] out_ff [2];
logic por_ff;

always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        in_ff[0] <= DATA_RST;
        in_ff[1] <= DATA_RST;
    end else if (exec && (upd || lfunc == LF_INPUT)) begin
        in_ff[sel] <= data;
    end
end

// sleep bits never touch these registers, so codes survive power-down
always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        out_ff[0] <= DATA_RST;
        out_ff[1] <= DATA_RST;
    end else if (exec) begin
        if (upd) begin
            out_ff[0] <= sel ? in_ff[0] : data;
            out_ff[1] <= sel ? data : in_ff[1];
        end else begin
            unique case (lfunc)
                LF_BOTH: begin
                    out_ff[0] <= data;
                    out_ff[1] <= data;
                end
                LF_INPUT: begin
                end
                LF_COPY: begin
                    out_ff[sel] <= in_ff[sel];
                end
                LF_DIRECT: begin
                    out_ff[sel] <= data;
                end
            endcase
        end
    end
end

always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        por_ff <= 1'b1;
    end else if (exec) begin
        por_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// reference and power

logic ref_int_ff;
logic [1:0] sleep_ff;
logic bias_ff;
logic [1:0] amp_on_ff;
logic [9:0] wait_ff [2];
logic [1:0] valid_ff;

always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        ref_int_ff <= 1'b1;
        sleep_ff <= 2'h0;
        bias_ff <= 1'b1;
        amp_on_ff <= 2'h3;
    end else if (exec) begin
        ref_int_ff <= ~word_ff[BIT_REF];
        sleep_ff <= nxt_sleep;
        bias_ff <= ~&nxt_sleep;
        amp_on_ff <= ~nxt_sleep;
    end
end

// wake time depends on whether the shared bias was also down
always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        wait_ff[0] <= 10'h000;
        wait_ff[1] <= 10'h000;
        valid_ff <= 2'h3;
    end else begin
        for (int ch = 0; ch < 2; ch++) begin
            if (exec && nxt_sleep[ch]) begin
                valid_ff[ch] <= 1'b0;
                wait_ff[ch] <= 10'h000;
            end else if (exec && sleep_ff[ch]) begin
                valid_ff[ch] <= 1'b0;
                wait_ff[ch] <= (&sleep_ff) ? WAKE_FULL_CYC : WAKE_PART_CYC;
            end else if (wait_ff[ch] != 10'h000) begin
                wait_ff[ch] <= wait_ff[ch] - 10'h001;
                valid_ff[ch] <= (wait_ff[ch] == 10'h001);
            end
        end
    end
end

assign o_dac_a = out_ff[0];
assign o_dac_b = out_ff[1];
assign o_transparent = por_ff;
assign o_ref_internal = ref_int_ff;
assign o_amp_on_a = amp_on_ff[0];
assign o_amp_on_b = amp_on_ff[1];
assign o_bias_on = bias_ff;
assign o_valid_a = valid_ff[0];
assign o_valid_b = valid_ff[1];

endmodule : dsc_dac_dev

// file: rtl/dsc_host.sv
// Purpose: host end: sends one 16-bit word per request over the link
// Assumes: link clock made here by dividing the system clock
// Notes: clock idles low, data moves on falling edges
module dsc_host import dsc_pkg::*; (
    // system
    input wire logic i_clk,
    input wire logic i_resetn,
    // serial link
    dsc_link_if.host link,
    // user request
    input wire logic i_start,
    input wire logic [15:0] i_word,
    input wire logic i_byte_mode,
    input wire logic i_lsb_first,
    // user status
    output logic o_busy,
    output logic o_done
);

typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_GAP, ST_TAIL} dsc_host_state_type;

function automatic logic [15:0] reverse16(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < WORD_W; i++) begin
        r[i] = w[WORD_W - 1 - i];
    end
    return r;
endfunction : reverse16

dsc_host_state_type state_ff;
logic [3:0] div_ff;
logic [3:0] bit_ff;
logic [15:0] tx_ff;
logic sync_n_ff;
logic sclk_ff;
logic din_ff;
logic busy_ff;
logic done_ff;
logic byte_ff;

////////////////////////////////////////////////////////////////////////////////
// link sequencer

always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
        state_ff <= ST_IDLE;
        div_ff <= 4'h0;
        bit_ff <= 4'h0;
        tx_ff <= 16'h0000;
        sync_n_ff <= 1'b1;
        sclk_ff <= 1'b0;
        din_ff <= 1'b0;
        busy_ff <= 1'b0;
        done_ff <= 1'b0;
        byte_ff <= 1'b0;
    end else begin
        done_ff <= 1'b0;
        if (state_ff != ST_IDLE) begin
            div_ff <= div_ff + 4'h1;
        end
        unique case (state_ff)
            ST_IDLE: begin
                if (i_start) begin
                    tx_ff <= i_lsb_first ? reverse16(i_word) : i_word;
                    din_ff <= i_lsb_first ? i_word[0] : i_word[15];
                    byte_ff <= i_byte_mode;
                    sync_n_ff <= 1'b0;
                    busy_ff <= 1'b1;
                    bit_ff <= 4'h0;
                    div_ff <= 4'h0;
                    state_ff <= ST_LEAD;
                end
            end
            ST_LEAD, ST_LOW: begin
                if (div_ff == HOST_HALF_CYC - 4'h1) begin
                    sclk_ff <= 1'b1;
                    div_ff <= 4'h0;
                    state_ff <= ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (div_ff == HOST_HALF_CYC - 4'h1) begin
                    sclk_ff <= 1'b0;
                    div_ff <= 4'h0;
                    if (bit_ff == 4'hF) begin
                        state_ff <= ST_TAIL;
                    end else begin
                        din_ff <= tx_ff[14];
                        tx_ff <= {tx_ff[14:0], 1'b0};
                        bit_ff <= bit_ff + 4'h1;
                        // sync stays low over the byte gap
                        state_ff <= (byte_ff && bit_ff == 4'h7) ? ST_GAP : ST_LOW;
                    end
                end
            end
            ST_GAP: begin
                if (div_ff == HOST_GAP_CYC - 4'h1) begin
                    div_ff <= HOST_HALF_CYC - 4'h1;
                    state_ff <= ST_LOW;
                end
            end
            ST_TAIL: begin
                if (div_ff == HOST_HALF_CYC - 4'h1) begin
                    sync_n_ff <= 1'b1;
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    state_ff <= ST_IDLE;
                end
            end
        endcase
    end
end

assign link.sync_n = sync_n_ff;
assign link.sclk = sclk_ff;
assign link.din = din_ff;
assign o_busy = busy_ff;
assign o_done = done_ff;

endmodule : dsc_host

// file: rtl/dsc_link_if.sv
// Purpose: three-wire serial link between host and converter control
// Assumes: host owns every wire
// Notes: link clock idles low between frames
interface dsc_link_if;
    logic sync_n;
    logic sclk;
    logic din;
    modport host (output sync_n, output sclk, output din);
    modport dev (input sync_n, input sclk, input din);
endinterface : dsc_link_if

// file: rtl/dsc_pkg.sv
// Purpose: shared constants for the dual converter serial control link
// Assumes: 40 MHz system clock on both ends
// Notes: word travels bit 15 first
//
// Summary of operation
// - update 0, code 00: data to both outputs
// - update 0, code 01: data to selected input
// - update 0, code 10: selected input copied to output
// - update 0, code 11: data to selected output
// - update 1: load input, then update both outputs
// - reference bit 0 selects internal half-supply reference
// - sleep bits power down channels independently
// - sleep shuts channel circuitry; both stop bias
// - sleep never alters input or output registers
// - leaving full power-down takes 13 us
// - single channel wakes in 1.6 us
// - power-up zeroes inputs, outputs transparent at ground
// - reset state holds until first completed write
// - host changes data on falling clock edge
// - byte host keeps sync low across both bytes
// - words travel most significant bit first; host with i_lsb_first set sends i_word bit 0 first
// - host makes clock, active-low frame, 16-bit words
// - host uses clock polarity 0, phase 0
// - control field layout in bits 15 to 8
// - bits 7 to 0 are data, bit 7 MSB
// - shift on rising clock while sync low
// - sync rising after sixteen bits executes word
package dsc_pkg;
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;
    localparam int BIT_REF = 15;
    localparam int BIT_UPD = 13;
    localparam int BIT_SLP_B = 12;
    localparam int BIT_SLP_A = 11;
    localparam int BIT_SEL = 10;
    localparam int BIT_LF_HI = 9;
    localparam int BIT_LF_LO = 8;
    localparam logic [1:0] LF_BOTH = 2'h0;
    localparam logic [1:0] LF_INPUT = 2'h1;
    localparam logic [1:0] LF_COPY = 2'h2;
    localparam logic [1:0] LF_DIRECT = 2'h3;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_OVER = 5'h11;
    localparam int CLK_KHZ = 40000;
    localparam int WAKE_FULL_NS = 13000;
    localparam int WAKE_PART_NS = 1600;
    localparam logic [9:0] WAKE_FULL_CYC = 10'((WAKE_FULL_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [9:0] WAKE_PART_CYC = 10'((WAKE_PART_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [3:0] HOST_HALF_CYC = 4'h2;
    localparam logic [3:0] HOST_GAP_CYC = 4'h6;
endpackage : dsc_pkg

// file: testbench/dsc_dual_dac_serial_control_bench.sv
// Purpose: end-to-end bench, host end driving converter end
// Assumes: 40 MHz i_clk, link clock made by the host
// Notes: second device is bit-banged to send broken frames
////////////////////////////////////////////////////////////////////////////////
module dsc_dual_dac_serial_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic start = 1'b0;
    logic bmode = 1'b0;
    logic lsbf = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [15:0] cap;
    logic busy, done, tr, tr2, ref_i, amp_a, amp_b, bias, va, vb;
    logic [7:0] da, db, da2, db2;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    dsc_link_if link ();
    dsc_link_if link2 ();
    dsc_host dsc_host_inst (.i_clk(i_clk), .i_resetn(i_resetn), .link(link.host),
        .i_start(start), .i_word(word), .i_byte_mode(bmode), .i_lsb_first(lsbf),
        .o_busy(busy), .o_done(done));
    dsc_dac_dev dsc_dac_dev_inst (.i_clk(i_clk), .i_resetn(i_resetn), .link(link.dev),
        .o_dac_a(da), .o_dac_b(db), .o_transparent(tr), .o_ref_internal(ref_i),
        .o_amp_on_a(amp_a), .o_amp_on_b(amp_b), .o_bias_on(bias), .o_valid_a(va),
        .o_valid_b(vb));
    dsc_dac_dev dsc_dac_dev_inst_b (.i_clk(i_clk), .i_resetn(i_resetn), .link(link2.dev),
        .o_dac_a(da2), .o_dac_b(db2), .o_transparent(tr2), .o_ref_internal(),
        .o_amp_on_a(), .o_amp_on_b(), .o_bias_on(), .o_valid_a(), .o_valid_b());
    dsc_link_checker dsc_link_checker_inst (.i_clk(i_clk), .i_resetn(i_resetn),
        .sync_n(link.sync_n), .sclk(link.sclk), .din(link.din));
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge link.sclk) if (!link.sync_n) cap <= {cap[14:0], link.din};
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one word through the host; returns well after the device has executed it
    task automatic send(input logic [15:0] w, input logic bm = 1'b0, input logic lf = 1'b0);
        logic [15:0] e;
        int n;
        for (int i = 0; i < 16; i++) e[i] = lf ? w[15 - i] : w[i];
        @(posedge i_clk);
        start <= 1'b1;
        word <= w;
        bmode <= bm;
        lsbf <= lf;
        @(posedge i_clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        chk({busy, done}, 2'b01);
        repeat (6) @(negedge i_clk);
        chk(cap, e);
        chk({link.sync_n, link.sclk}, 2'b10);
    endtask : send
    // second link by hand, any bit count; 6 ns link clock, off i_clk phase, idle outside frames
    task automatic bang(input logic [16:0] w, input int nb);
        @(posedge i_clk);
        link2.sync_n <= 1'b0;
        #7;
        for (int i = nb - 1; i >= 0; i--) begin
            link2.din = w[i];
            #3;
            link2.sclk = 1'b1;
            #3;
            link2.sclk = 1'b0;
        end
        repeat (5) @(posedge i_clk);
        link2.sync_n <= 1'b1;
        link2.din <= ~link2.din;
        repeat (8) @(negedge i_clk);
    endtask : bang
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({da, db, tr}, 17'h00001);
        chk({ref_i, amp_a, amp_b, bias, va, vb}, 6'h3F);
    endtask : t_reset
    task automatic t_loads();
        send(16'h5A00, 1'b0, 1'b1);
        chk({da, db, tr, ref_i}, 18'h16969);
        send(16'h0533, 1'b1);
        chk({da, db}, 16'h5A5A);
        send(16'h0600);
        chk({da, db}, 16'h5A33);
        send(16'h03C3);
        chk({da, db}, 16'hC333);
        send(16'h8700);
        chk({da, db, ref_i}, 17'h18600);
        send(16'h0111);
        chk({da, db}, 16'hC300);
        send(16'h2777);
        chk({da, db}, 16'h1177);
    endtask : t_loads
    task automatic t_sleep();
        send(16'h0D00);
        chk({amp_a, amp_b, bias, va, vb, da, db}, 21'h0D1177);
        send(16'h1D00);
        chk({amp_a, amp_b, bias, da, db}, 19'h01177);
        send(16'h0500);
        repeat (495) @(negedge i_clk);
        chk(va, 1'b0);
        repeat (30) @(negedge i_clk);
        chk({va, vb, amp_a, amp_b, bias}, 5'h1F);
        send(16'h1500);
        chk({amp_a, amp_b, bias, vb, da, db}, 20'hA1177);
        send(16'h0500);
        repeat (55) @(negedge i_clk);
        chk(vb, 1'b0);
        repeat (15) @(negedge i_clk);
        chk({va, vb}, 2'b11);
    endtask : t_sleep
    task automatic t_broken();
        bang(17'h000FF, 15);
        chk({da2, db2, tr2}, 17'h00001);
        bang(17'h100FF, 17);
        chk({da2, db2, tr2}, 17'h00001);
        bang(17'h000AB, 16);
        chk({da2, db2, tr2}, 17'h15756);
    endtask : t_broken
    initial begin
        link2.sync_n = 1'b1;
        link2.sclk = 1'b0;
        link2.din = 1'b0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        t_reset();
        t_loads();
        t_sleep();
        t_broken();
        finish_test();
    end
endmodule : dsc_dual_dac_serial_control_bench

// file: testbench/dsc_link_checker.sv
// Purpose: protocol checks on the link wires driven by the host end
// Assumes: host makes sclk as i_clk/4, idle low
// Notes: sees only the interface wires
////////////////////////////////////////////////////////////////////////////////
module dsc_link_checker (
    // system
    input wire logic i_clk,
    input wire logic i_resetn,
    // link wires
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] rise_cnt_ff;
    logic sclk_d_ff;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk;
        end
    end
    // rises inside the open frame; cleared while idle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rise_cnt_ff <= 5'h00;
        end else if (sync_n) begin
            rise_cnt_ff <= 5'h00;
        end else if (sclk && !sclk_d_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_idle_low; sync_n |-> !sclk; endproperty
    a_idle_low: assert property (p_idle_low) else $error("sclk high outside frame");
    property p_rise_hold; $rose(sclk) |-> $stable(din); endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("din moved at sclk rise");
    property p_high_hold; sclk && sclk_d_ff |-> $stable(din); endproperty
    a_high_hold: assert property (p_high_hold) else $error("din moved while sclk high");
    property p_half; $rose(sclk) |-> ##1 sclk ##1 !sclk; endproperty
    a_half: assert property (p_half) else $error("sclk high phase wrong");
    property p_lead; $fell(sync_n) |-> !sclk ##1 !sclk ##1 sclk; endproperty
    a_lead: assert property (p_lead) else $error("first rise misplaced");
    property p_count; $rose(sync_n) |-> rise_cnt_ff == 5'h10; endproperty
    a_count: assert property (p_count) else $error("frame not sixteen rises");
    property p_len; $fell(sync_n) |-> ##[66:72] $rose(sync_n); endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
    property p_tail; $rose(sync_n) |-> $past(sclk, 3) && !$past(sclk, 2); endproperty
    a_tail: assert property (p_tail) else $error("sync rose too near sclk");
endmodule : dsc_link_checker
